// >>> rtl/regulator_fault_defs.vh
// Register indices, field positions and timing constants of the fault flags.
`ifndef REGULATOR_FAULT_DEFS_VH
`define REGULATOR_FAULT_DEFS_VH

// Register indices; the byte address is four times the index.
`define IDX_SWRESET 8'h18
`define IDX_TOP 8'h19
`define IDX_RESET_EVENT 8'h1A
`define IDX_STEPDOWN 8'h1B
`define IDX_LINREG 8'h1C
`define IDX_MASK_RESET 8'h20
`define IDX_MASK_STEPDOWN 8'h21
`define IDX_MASK_LINREG 8'h22

// Field positions.
`define BIT_SWRESET 0
`define BIT_RESET_EVENT 0
`define BIT_SUM_STEPDOWN 5
`define BIT_SUM_LINREG 6
`define BIT_PG1 6
`define BIT_SC1 5
`define BIT_IL1 4
`define BIT_PG0 2
`define BIT_SC0 1
`define BIT_IL0 0

// Reset values and writable field masks.
`define FLAGS_DEFAULT 8'h00
`define MASK_DEFAULT 8'h00
`define UNIT_FLAG_BITS 8'h77
`define RESET_FLAG_BITS 8'h01

// Timing.
`define CLK_MHZ 100
`define SHORT_TIME_US 1000
`define SHORT_CNT_W 17
`define STARTUP_CYCLES_DEF 8'h10

`endif

// >>> rtl/short_persist_filter.v
// Synchronised short-circuit input with a persistence timer.
`timescale 1ns/1ps
module short_persist_filter #(
    parameter CW = 17,
    parameter [CW-1:0] CYCLES = 100000
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Short indication pin, high while below threshold
    input wire short_pin,
    // One-cycle pulse once the short has persisted
    output reg expired_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg level_r;
    reg done_r;
    reg [CW-1:0] cnt_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= {CW{1'b0}};
            expired_r <= 1'b0;
        end else begin
            s1_r <= short_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
            expired_r <= 1'b0;
            if (!level_r) begin
                cnt_r <= {CW{1'b0}};
                done_r <= 1'b0;
            end else if (cnt_r != CYCLES) begin
                cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end else if (!done_r) begin
                // Still low one sample past the full time: longer than it.
                expired_r <= 1'b1;
                done_r <= 1'b1;
            end
        end
    end
endmodule // short_persist_filter

// >>> rtl/regulator_fault_flag_latches.v
// Latched regulator fault and reset-event flags behind an AHB-Lite slave.
//
// How it works
// - Supply undervoltage sets reset-event flag.
// - Software reset request sets reset-event flag.
// - Reset event: regulators off, defaults, restart.
// - Reset-event flag held until host writes one.
// - Step-down power-good events latch bits 6, 2.
// - Step-down short over 1 ms latches bits 5, 1.
// - Step-down current limit latches bits 4, 0.
// - Linear power-good events latch bits 6, 2.
// - Linear short over 1 ms latches bits 5, 1.
// - Linear current limit latches bits 4, 0.
// - Flags reset zero, stay, one-clears only that.
// - Summary bits clear when flag register empties.
// - Software reset bit clears itself once started.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "regulator_fault_defs.vh"
module regulator_fault_flag_latches #(
    parameter [`SHORT_CNT_W-1:0] SHORT_CYCLES =
        `SHORT_TIME_US * `CLK_MHZ,
    parameter [7:0] STARTUP_CYCLES = `STARTUP_CYCLES_DEF
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata_r,
    output reg hreadyout_r,
    output reg hresp_r,
    // Analog monitor pins, asynchronous
    input wire analog_supply_low,
    input wire [1:0] stepdown_pg_fault,
    input wire [1:0] stepdown_short,
    input wire [1:0] stepdown_curlimit,
    input wire [1:0] linreg_pg_fault,
    input wire [1:0] linreg_short,
    input wire [1:0] linreg_curlimit,
    // Control outputs
    output reg regulators_off_r,
    output reg irq_r
);
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_SHUTDOWN = 3'b010;
    localparam [2:0] ST_STARTUP = 3'b100;

    // Places one unit's pg, short and limit events in the flag layout.
    function [7:0] pack_flags;
        input [1:0] pg;
        input [1:0] sc;
        input [1:0] il;
        begin
            pack_flags = `FLAGS_DEFAULT;
            pack_flags[`BIT_PG1] = pg[1];
            pack_flags[`BIT_SC1] = sc[1];
            pack_flags[`BIT_IL1] = il[1];
            pack_flags[`BIT_PG0] = pg[0];
            pack_flags[`BIT_SC0] = sc[0];
            pack_flags[`BIT_IL0] = il[0];
        end
    endfunction

    // Register index hit for a word-aligned address below 1 KiB.
    function hit;
        input [31:0] addr;
        input [7:0] idx;
        begin
            hit = (addr[31:10] == 22'h00_0000) && (addr[9:2] == idx);
        end
    endfunction

    // Clear pattern of a write-one-to-clear access, real fields only.
    function [7:0] clr_bits;
        input wr;
        input [7:0] data;
        input [7:0] fields;
        begin
            clr_bits = wr ? (data & fields) : `FLAGS_DEFAULT;
        end
    endfunction

    // Sticky update: a one clears its own bit, a new event still wins.
    function [7:0] sticky_nxt;
        input [7:0] cur;
        input [7:0] clr;
        input [7:0] set;
        begin
            sticky_nxt = (cur & ~clr) | set;
        end
    endfunction

    // True while any flag is set that its mask lets through.
    function pending;
        input [7:0] flags;
        input [7:0] mask;
        begin
            pending = |(flags & ~mask);
        end
    endfunction

    // Pin synchronisers: uv, lr_il, lr_pg, sd_il, sd_pg.
    wire [8:0] pins;
    reg [8:0] s1_r;
    reg [8:0] s2_r;
    reg [8:0] s3_r;
    reg [8:0] lvl_r;
    reg [8:0] lvl_d_r;
    assign pins = {analog_supply_low, linreg_curlimit, linreg_pg_fault,
                   stepdown_curlimit, stepdown_pg_fault};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 9'h000;
            s2_r <= 9'h000;
            s3_r <= 9'h000;
            lvl_r <= 9'h000;
            lvl_d_r <= 9'h000;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A level moves only once stages two and three agree.
            lvl_r <= (lvl_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
            lvl_d_r <= lvl_r;
        end
    end

    wire uv_low = lvl_r[8];
    wire [1:0] sd_pg_ev = lvl_r[1:0] & ~lvl_d_r[1:0];
    wire [1:0] sd_il = lvl_r[3:2];
    wire [1:0] lr_pg_ev = lvl_r[5:4] & ~lvl_d_r[5:4];
    wire [1:0] lr_il = lvl_r[7:6];

    wire [3:0] sc_ev;
    wire [3:0] sc_pins = {linreg_short, stepdown_short};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_short
            short_persist_filter #(
                .CW(`SHORT_CNT_W),
                .CYCLES(SHORT_CYCLES)
            ) u_short (
                .hclk(hclk),
                .hresetn(hresetn),
                .short_pin(sc_pins[gi]),
                .expired_r(sc_ev[gi])
            );
        end
    endgenerate

    // Bus slave: one wait state, action taken in the first data cycle.
    reg pend_r;
    reg pend_wr_r;
    reg [31:0] pend_addr_r;
    wire accept = hsel && htrans[1] && hready;
    wire act_wr = pend_r && pend_wr_r;
    wire act_rd = pend_r && !pend_wr_r;

    reg [7:0] rst_flags_r;
    reg [7:0] sd_flags_r;
    reg [7:0] lr_flags_r;
    reg [7:0] mask_rst_r;
    reg [7:0] mask_sd_r;
    reg [7:0] mask_lr_r;
    reg swreset_r;
    reg [2:0] state_r;
    reg [7:0] start_cnt_r;

    wire wr_swreset = act_wr && hit(pend_addr_r, `IDX_SWRESET);
    wire wr_rst = act_wr && hit(pend_addr_r, `IDX_RESET_EVENT);
    wire wr_sd = act_wr && hit(pend_addr_r, `IDX_STEPDOWN);
    wire wr_lr = act_wr && hit(pend_addr_r, `IDX_LINREG);
    wire wr_mrst = act_wr && hit(pend_addr_r, `IDX_MASK_RESET);
    wire wr_msd = act_wr && hit(pend_addr_r, `IDX_MASK_STEPDOWN);
    wire wr_mlr = act_wr && hit(pend_addr_r, `IDX_MASK_LINREG);

    wire reset_event = uv_low || swreset_r;
    wire in_seq = (state_r != ST_RUN);
    wire wipe = (state_r == ST_SHUTDOWN) ||
                (state_r == ST_RUN && reset_event);

    wire [7:0] sd_set = pack_flags(sd_pg_ev, sc_ev[1:0], sd_il);
    wire [7:0] lr_set = pack_flags(lr_pg_ev, sc_ev[3:2], lr_il);
    wire [7:0] rst_set = {7'h00, reset_event};

    // A one clears only its own bit, zeros do nothing, set wins.
    wire [7:0] rst_clr = clr_bits(wr_rst, hwdata[7:0], `RESET_FLAG_BITS);
    wire [7:0] sd_clr = clr_bits(wr_sd, hwdata[7:0], `UNIT_FLAG_BITS);
    wire [7:0] lr_clr = clr_bits(wr_lr, hwdata[7:0], `UNIT_FLAG_BITS);
    wire [7:0] rst_flags_nxt =
        sticky_nxt(rst_flags_r, rst_clr, rst_set);
    wire [7:0] sd_flags_nxt =
        sticky_nxt(sd_flags_r, sd_clr, sd_set);
    wire [7:0] lr_flags_nxt =
        sticky_nxt(lr_flags_r, lr_clr, lr_set);

    // Summary bits follow the flag registers, so they drop with them.
    wire sum_sd = |sd_flags_r;
    wire sum_lr = |lr_flags_r;

    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (hit(pend_addr_r, `IDX_SWRESET)) begin
            rd_byte[`BIT_SWRESET] = swreset_r;
        end else if (hit(pend_addr_r, `IDX_TOP)) begin
            rd_byte[`BIT_SUM_STEPDOWN] = sum_sd;
            rd_byte[`BIT_SUM_LINREG] = sum_lr;
        end else if (hit(pend_addr_r, `IDX_RESET_EVENT)) begin
            rd_byte = rst_flags_r;
        end else if (hit(pend_addr_r, `IDX_STEPDOWN)) begin
            rd_byte = sd_flags_r;
        end else if (hit(pend_addr_r, `IDX_LINREG)) begin
            rd_byte = lr_flags_r;
        end else if (hit(pend_addr_r, `IDX_MASK_RESET)) begin
            rd_byte = mask_rst_r;
        end else if (hit(pend_addr_r, `IDX_MASK_STEPDOWN)) begin
            rd_byte = mask_sd_r;
        end else if (hit(pend_addr_r, `IDX_MASK_LINREG)) begin
            rd_byte = mask_lr_r;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_addr_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
            if (pend_r) begin
                pend_r <= 1'b0;
                hreadyout_r <= 1'b1;
                // Read data then stands until the next read completes.
                if (act_rd) begin
                    hrdata_r <= {24'h00_0000, rd_byte};
                end
            end else if (accept) begin
                pend_r <= 1'b1;
                pend_wr_r <= hwrite;
                pend_addr_r <= haddr;
                hreadyout_r <= 1'b0;
            end
        end
    end

    // Reset-event sequencer.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
            start_cnt_r <= 8'h00;
            swreset_r <= 1'b0;
            regulators_off_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (reset_event) begin
                        state_r <= ST_SHUTDOWN;
                        swreset_r <= 1'b0;
                        regulators_off_r <= 1'b1;
                    end else if (wr_swreset && hwdata[`BIT_SWRESET]) begin
                        swreset_r <= 1'b1;
                    end
                end
                ST_SHUTDOWN: begin
                    // Held here while the supply stays low.
                    swreset_r <= 1'b0;
                    if (!uv_low) begin
                        state_r <= ST_STARTUP;
                        start_cnt_r <= STARTUP_CYCLES;
                    end
                end
                ST_STARTUP: begin
                    // A new undervoltage restarts the whole sequence.
                    if (uv_low) begin
                        state_r <= ST_SHUTDOWN;
                    end else if (start_cnt_r == 8'h00) begin
                        state_r <= ST_RUN;
                        regulators_off_r <= 1'b0;
                    end else begin
                        start_cnt_r <= start_cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // Flag and mask storage.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_flags_r <= `FLAGS_DEFAULT;
            sd_flags_r <= `FLAGS_DEFAULT;
            lr_flags_r <= `FLAGS_DEFAULT;
            mask_rst_r <= `MASK_DEFAULT;
            mask_sd_r <= `MASK_DEFAULT;
            mask_lr_r <= `MASK_DEFAULT;
        end else begin
            rst_flags_r <= rst_flags_nxt;
            if (wipe) begin
                // Every other register returns to its default.
                sd_flags_r <= `FLAGS_DEFAULT;
                lr_flags_r <= `FLAGS_DEFAULT;
                mask_rst_r <= `MASK_DEFAULT;
                mask_sd_r <= `MASK_DEFAULT;
                mask_lr_r <= `MASK_DEFAULT;
            end else begin
                sd_flags_r <= sd_flags_nxt;
                lr_flags_r <= lr_flags_nxt;
                if (wr_mrst) begin
                    mask_rst_r <= hwdata[7:0] & `RESET_FLAG_BITS;
                end
                if (wr_msd) begin
                    mask_sd_r <= hwdata[7:0] & `UNIT_FLAG_BITS;
                end
                if (wr_mlr) begin
                    mask_lr_r <= hwdata[7:0] & `UNIT_FLAG_BITS;
                end
            end
        end
    end

    // Interrupt line, one cycle behind the flags and masks.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= pending(rst_flags_r, mask_rst_r) |
                     pending(sd_flags_r, mask_sd_r) |
                     pending(lr_flags_r, mask_lr_r);
        end
    end
    wire unused_ok = &{1'b0, hsize, in_seq};
endmodule // regulator_fault_flag_latches

// >>> bench/regulator_fault_checker.sv
// Port-level assertions for the regulator fault flag block.
`timescale 1ns/1ps
module regulator_fault_checker (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hready,
    input wire [31:0] hrdata_r,
    input wire hreadyout_r,
    input wire hresp_r,
    // Monitor pins and outputs
    input wire analog_supply_low,
    input wire [1:0] linreg_curlimit,
    input wire regulators_off_r,
    input wire irq_r
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp_r == 1'b0)
        else $error("slave gave an error response");
    a_one_wait: assert property (hsel && htrans[1] && hready
        |=> !hreadyout_r ##1 hreadyout_r)
        else $error("data phase is not two cycles");
    a_wait_short: assert property (!hreadyout_r |=> hreadyout_r)
        else $error("wait state longer than one cycle");
    a_data_narrow: assert property (hrdata_r[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_reset_idle: assert property ($rose(hresetn)
        |-> hreadyout_r && !irq_r && !regulators_off_r)
        else $error("outputs not idle after reset");
    a_uv_shutdown: assert property ($rose(analog_supply_low)
        |-> ##[1:10] regulators_off_r)
        else $error("undervoltage did not shut regulators off");
    a_off_while_low: assert property (analog_supply_low &&
        regulators_off_r |=> regulators_off_r)
        else $error("regulators restarted while supply low");
    a_startup_min: assert property ($fell(analog_supply_low) &&
        regulators_off_r |=> regulators_off_r[*8])
        else $error("startup sequence too short");
    a_startup_max: assert property ($fell(analog_supply_low)
        |-> ##[1:40] !regulators_off_r)
        else $error("startup sequence never ended");
    a_limit_irq: assert property ((linreg_curlimit[0] &&
        !regulators_off_r)[*8] |-> irq_r)
        else $error("current limit raised no interrupt");
    c_shutdown: cover property (regulators_off_r ##1 !regulators_off_r);
    c_irq: cover property ($rose(irq_r));
    c_wait: cover property (!hreadyout_r);
endmodule // regulator_fault_checker

bind regulator_fault_flag_latches regulator_fault_checker chk (.*);

// >>> bench/regulator_fault_flag_latches_tb.sv
// Self-checking bench for the regulator fault flag block.
`timescale 1ns/1ps
`include "regulator_fault_defs.vh"
module regulator_fault_flag_latches_tb;
    localparam SC = 20;
    reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, uv = 0;
    reg [1:0] htrans = 0;
    reg [31:0] haddr = 0, hwdata = 0, rd;
    reg [11:0] pins = 0;
    reg [7:0] idx;
    wire [31:0] hrdata_r;
    wire hreadyout_r, hresp_r, regulators_off_r, irq_r;
    integer error_cnt = 0, n_tests = 0, cyc = 0, i, b, p;

    regulator_fault_flag_latches #(.SHORT_CYCLES(17'd20)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout_r), .hwdata(hwdata), .hrdata_r(hrdata_r),
        .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
        .analog_supply_low(uv), .stepdown_pg_fault(pins[5:4]),
        .stepdown_short(pins[3:2]), .stepdown_curlimit(pins[1:0]),
        .linreg_pg_fault(pins[11:10]), .linreg_short(pins[9:8]),
        .linreg_curlimit(pins[7:6]), .regulators_off_r(regulators_off_r),
        .irq_r(irq_r));

    initial forever #5 hclk = ~hclk;

    task close_out;
        begin
            $display("compares %0d bad %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
    end

    task chk(input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    endtask

    task chk1(input e, input g);
        chk({31'd0, e}, {31'd0, g});
    endtask

    // One single AHB-Lite word transfer; rd holds read data afterwards.
    task xfer(input w, input [7:0] a, input [31:0] wd);
        begin
            haddr <= {22'd0, a, 2'b00};
            hsel <= 1'b1;
            htrans <= 2'b10;
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout_r !== 1'b1) @(posedge hclk);
            htrans <= 2'b00;
            hwdata <= wd;
            @(posedge hclk);
            while (hreadyout_r !== 1'b1) @(posedge hclk);
            rd = hrdata_r;
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            chk(e, rd);
        end
    endtask

    function integer flag_pos(input integer j);
        flag_pos = j < 3 ? j : j + 1;
    endfunction

    function [31:0] top_exp(input integer i);
        top_exp = 32'h1 << (i < 6 ? `BIT_SUM_STEPDOWN : `BIT_SUM_LINREG);
    endfunction

    initial begin
        b = $urandom(71);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(`IDX_RESET_EVENT, `FLAGS_DEFAULT);
        rdchk(`IDX_STEPDOWN, `FLAGS_DEFAULT);
        rdchk(`IDX_LINREG, `FLAGS_DEFAULT);
        xfer(1'b1, 8'h30, 32'h0000_00ff);
        rdchk(8'h30, 32'h0);
        $display("defaults done");
        for (i = 0; i < 12; i = i + 1) begin
            idx = i < 6 ? `IDX_STEPDOWN : `IDX_LINREG;
            b = flag_pos(i % 6);
            p = (i < 6 ? 0 : 6) + 2 * (b % 4) + b / 4;
            pins[p] <= 1'b1;
            repeat (b % 4 == 1 ? SC + 10 : $urandom_range(3, 9))
                @(posedge hclk);
            pins <= 12'h000;
            repeat (10) @(posedge hclk);
            rdchk(idx, 32'h1 << b);
            rdchk(`IDX_TOP, top_exp(i));
            chk1(1'b1, irq_r);
            xfer(1'b1, idx, $urandom & ~(32'h1 << b));
            rdchk(idx, 32'h1 << b);
            xfer(1'b1, idx, 32'h1 << b);
            rdchk(idx, 32'h0);
            rdchk(`IDX_TOP, 32'h0);
        end
        $display("events done");
        pins[$urandom_range(2, 3)] <= 1'b1;
        repeat (SC / 2) @(posedge hclk);
        pins <= 12'h000;
        repeat (10) @(posedge hclk);
        rdchk(`IDX_STEPDOWN, 32'h0);
        xfer(1'b1, `IDX_MASK_STEPDOWN, 32'h0000_00ff);
        pins[0] <= 1'b1;
        repeat (10) @(posedge hclk);
        pins <= 12'h000;
        repeat (5) @(posedge hclk);
        chk1(1'b0, irq_r);
        rdchk(`IDX_STEPDOWN, 32'h1);
        xfer(1'b1, `IDX_MASK_STEPDOWN, 32'h0);
        repeat (3) @(posedge hclk);
        chk1(1'b1, irq_r);
        xfer(1'b1, `IDX_STEPDOWN, 32'h1);
        $display("mask done");
        pins[6] <= 1'b1;
        repeat (10) @(posedge hclk);
        xfer(1'b1, `IDX_LINREG, 32'h1);
        rdchk(`IDX_LINREG, 32'h1);
        pins <= 12'h000;
        repeat (8) @(posedge hclk);
        xfer(1'b1, `IDX_LINREG, 32'h1);
        rdchk(`IDX_LINREG, 32'h0);
        $display("set over clear done");
        xfer(1'b1, `IDX_MASK_RESET, 32'h0000_00ff);
        rdchk(`IDX_MASK_RESET, `RESET_FLAG_BITS);
        xfer(1'b1, `IDX_MASK_LINREG, 32'h0000_00ff);
        rdchk(`IDX_MASK_LINREG, `UNIT_FLAG_BITS);
        pins[1] <= 1'b1;
        repeat (10) @(posedge hclk);
        pins <= 12'h000;
        repeat (6) @(posedge hclk);
        uv <= 1'b1;
        repeat (12) @(posedge hclk);
        chk1(1'b1, regulators_off_r);
        rdchk(`IDX_STEPDOWN, 32'h0);
        rdchk(`IDX_RESET_EVENT, 32'h1);
        rdchk(`IDX_MASK_LINREG, 32'h0);
        uv <= 1'b0;
        repeat (40) @(posedge hclk);
        chk1(1'b0, regulators_off_r);
        rdchk(`IDX_RESET_EVENT, 32'h1);
        chk1(1'b1, irq_r);
        xfer(1'b1, `IDX_RESET_EVENT, 32'h1);
        rdchk(`IDX_RESET_EVENT, 32'h0);
        $display("undervoltage done");
        xfer(1'b1, `IDX_SWRESET, 32'h1);
        repeat (4) @(posedge hclk);
        rdchk(`IDX_SWRESET, 32'h0);
        rdchk(`IDX_RESET_EVENT, 32'h1);
        repeat (40) @(posedge hclk);
        chk1(1'b0, regulators_off_r);
        $display("software reset done");
        close_out;
    end
endmodule // regulator_fault_flag_latches_tb
